// ---- inc/hsd_pkg.sv ----
/*
 * Constants for the host speech decompression command interpreter:
 * register offsets, command codes, field positions and frame length.
 * Assumes a 16-bit command/status word path on the register port.
 */
`default_nettype none
package hsd_pkg;
   // Register offsets (word index on the register port)
   localparam logic [1:0]  OFS_CMD       = 2'h0;  // Command register, write only
   localparam logic [1:0]  OFS_STATUS    = 2'h1;  // Response / data word, read clears ready
   localparam logic [1:0]  OFS_HWSTAT    = 2'h2;  // Hardware status, read only
   localparam int          HW_RDY_BIT    = 0;
   localparam int          HW_ACT_BIT    = 1;
   localparam int          HW_XFER_BIT   = 2;

   // Start-decompression word fields
   localparam logic [5:0]  C1_TAG        = 6'h3f;
   localparam int          TAG_HI        = 15;
   localparam int          TAG_LO        = 10;
   localparam int          FMT_HI        = 9;
   localparam int          FMT_LO        = 7;
   localparam int          ZERO_HI       = 6;
   localparam int          ZERO_LO       = 3;
   localparam int          TFR_HI        = 2;
   localparam int          TFR_LO        = 1;
   localparam int          READY_BIT     = 0;

   // Playback formats that are reserved
   localparam logic [2:0]  FMT_RSV_A     = 3'h1;
   localparam logic [2:0]  FMT_RSV_B     = 3'h3;
   localparam logic [2:0]  FMT_RSV_C     = 3'h7;

   // Fixed command words and answers
   localparam logic [15:0] CMD_IDLE      = 16'h0000;
   localparam logic [15:0] CMD_DUMMY     = 16'hf000;
   localparam logic [15:0] QRY_DECOMP    = 16'h5219;
   localparam logic [15:0] QRY_COMP      = 16'h5119;
   localparam logic [15:0] ANS_READY     = 16'h0000;
   localparam logic [15:0] ANS_NOT_READY = 16'h0001;

   // Words in one uncompressed output frame
   localparam int          FRAME_WORDS   = 240;
endpackage
`default_nettype wire

// ---- sim/hsd_far_model.sv ----
/*
 * Behavioural far side of the decompression interpreter: a playback
 * engine that echoes forwarded words and a decompressed sample source.
 * Assumes the core's clock and reset; the bench picks a fast or slow engine.
 */
`default_nettype none
module hsd_far_model (
   input  wire  logic        clk,
   input  wire  logic        resetn,
   input  wire  logic        slow,
   input  wire  logic        pb_cmd_valid_q,
   input  wire  logic [15:0] pb_cmd_q,
   output logic              pb_resp_valid,
   output logic [15:0]       pb_resp_data,
   input  wire  logic        sample_pop_q,
   output logic [15:0]       sample_data
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0]  wait_q;
   logic [15:0] word_q;
   logic [7:0]  head_q;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wait_q        <= 4'h0;
         word_q        <= 16'h0000;
         pb_resp_valid <= 1'b0;
         pb_resp_data  <= 16'h0000;
      end else begin
         pb_resp_valid <= 1'b0;
         pb_resp_data  <= ~pb_resp_data;  // Idle line toggles so a stale word never looks valid
         if (pb_cmd_valid_q) begin
            word_q <= pb_cmd_q;
            wait_q <= slow ? 4'h6 : 4'h1;
         end else if (wait_q != 4'h0) begin
            wait_q <= wait_q - 4'h1;
            if (wait_q == 4'h1) begin
               pb_resp_valid <= 1'b1;
               pb_resp_data  <= word_q;
            end
         end
      end
   end

   // Head advances once per pop
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         head_q <= 8'h00;
      end else if (sample_pop_q) begin
         head_q <= head_q + 8'h01;
      end
   end
   assign sample_data = {head_q, ~head_q} ^ 16'h5a5a;
endmodule
`default_nettype wire

// ---- sim/test_host_speech_decompress_protocol.sv ----
/*
 * Self-checking bench for the decompression interpreter: host bus driver,
 * answer queue with a read monitor, and the far-side model.
 * Assumes the core answers every accepted command through status-ready.
 */
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
   $display("[FAIL] %s exp=%h got=%h", nm, e, g); end end
module test_host_speech_decompress_protocol;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [15:0] HALT_W = 16'h5200;
   logic        clk, resetn, wr, rd, frame_avail, comp_can_accept, slow, chk_d, chk_p, rsv;
   logic        pb_resp_valid, sample_pop_q, pb_cmd_valid_q, decomp_active_q;
   logic [1:0]  addr, transfer_method_q;
   logic [2:0]  playback_format_q;
   logic [15:0] wdata, rdata_q, sample_data, pb_cmd_q, pb_resp_data, exp_w, w;
   logic [31:0] rnd;
   logic [15:0] exp_q[$];
   int          n_errors, compares, pops, i;

   hsd_core #(.HALT_CMD(HALT_W)) u_dut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata_q(rdata_q), .frame_avail(frame_avail), .sample_data(sample_data), .sample_pop_q(sample_pop_q),
      .comp_can_accept(comp_can_accept), .pb_cmd_valid_q(pb_cmd_valid_q), .pb_cmd_q(pb_cmd_q),
      .pb_resp_valid(pb_resp_valid), .pb_resp_data(pb_resp_data), .decomp_active_q(decomp_active_q),
      .playback_format_q(playback_format_q), .transfer_method_q(transfer_method_q));
   hsd_far_model u_far (.clk(clk), .resetn(resetn), .slow(slow), .pb_cmd_valid_q(pb_cmd_valid_q),
      .pb_cmd_q(pb_cmd_q), .pb_resp_valid(pb_resp_valid), .pb_resp_data(pb_resp_data),
      .sample_pop_q(sample_pop_q), .sample_data(sample_data));

   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // Sample pattern the far side walks through
   function automatic logic [15:0] samp(input int n);
      logic [7:0] b;
      b = n[7:0];
      return {b, ~b} ^ 16'h5a5a;
   endfunction

   task automatic finish_test();
      $display("n_errors=%0d compares=%0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic wr_bus(input logic [1:0] a, input logic [15:0] d);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr    <= 1'b0;
   endtask
   // Checked reads leave their expectation in the queue
   task automatic rd_bus(input logic [1:0] a, input logic c, input logic [15:0] e);
      if (c) exp_q.push_back(e);
      rd    <= 1'b1;
      addr  <= a;
      chk_d <= c;
      @(posedge clk);
      rd    <= 1'b0;
      chk_d <= 1'b0;
   endtask
   // Bounded poll of status-ready; realigns to a rising edge each pass
   task automatic wait_rdy();
      int   k;
      logic ok;
      for (k = 0; k < 100; k++) begin
         rd_bus(hsd_pkg::OFS_HWSTAT, 1'b0, 16'h0000);
         @(negedge clk);
         ok = (rdata_q[hsd_pkg::HW_RDY_BIT] === 1'b1);
         @(posedge clk);
         if (ok) break;
      end
      if (k == 100) begin
         n_errors++;
         finish_test();
      end
   endtask
   task automatic cmd(input logic [15:0] cw, input logic [15:0] e);
      wr_bus(hsd_pkg::OFS_CMD, cw);
      wait_rdy();
      rd_bus(hsd_pkg::OFS_STATUS, 1'b1, e);
   endtask
   task automatic start_dec(input logic [2:0] f, input logic [1:0] m);
      logic [15:0] sw;
      sw = {hsd_pkg::C1_TAG, f, 4'h0, m, 1'b0};
      cmd(sw, sw);             // echo, ready clear
      cmd(16'h1a01, 16'h1a01); // second setup word
      cmd(16'h1a02, 16'h1a02); // third setup word
   endtask

   // Monitor: rdata stands only in the cycle after the read
   always @(posedge clk) begin
      chk_p <= rd && chk_d;
      if (chk_p) begin
         exp_w = exp_q.pop_front();
         `CHK("status word", exp_w, rdata_q)
      end
   end
   always @(posedge clk) begin
      if (sample_pop_q === 1'b1) pops++;
   end

   initial begin
      resetn          = 1'b0;
      wr              = 1'b0;
      rd              = 1'b0;
      addr            = 2'h0;
      wdata           = 16'h0000;
      chk_d           = 1'b0;
      frame_avail     = 1'b0;
      comp_can_accept = 1'b0;
      slow            = 1'b0;
      rnd             = 32'hf69eb43c;
      n_errors        = 0;
      compares        = 0;
      pops            = 0;
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      wr_bus(hsd_pkg::OFS_HWSTAT, 16'hffff);
      rd_bus(2'h3, 1'b1, 16'h0000);                      // unmapped reads zero
      @(posedge clk);
      rd_bus(hsd_pkg::OFS_HWSTAT, 1'b1, 16'h0000);       // status clear at idle
      cmd(hsd_pkg::QRY_DECOMP, hsd_pkg::ANS_NOT_READY);  // query while idle
      // Every format code, with a frame already waiting
      frame_avail <= 1'b1;
      for (i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         w   = {hsd_pkg::C1_TAG, i[2:0], 4'h0, rnd[1:0], 1'b0};
         rsv = (i == 1) || (i == 3) || (i == 7);
         cmd(w, w);                                       // ready flag clear
         `CHK("active", !rsv, decomp_active_q)
         if (!rsv) begin
            `CHK("format", i[2:0], playback_format_q)
            `CHK("method", rnd[1:0], transfer_method_q)
            if (i[0]) cmd(HALT_W, HALT_W);                // halt in second slot
            else cmd(hsd_pkg::CMD_IDLE, hsd_pkg::ANS_READY); // idle in second slot
            `CHK("ended", 1'b0, decomp_active_q)
         end
      end
      start_dec(3'h6, 2'h0);                              // start with setup words
      `CHK("pb word", 16'h1a02, pb_cmd_q)
      frame_avail <= 1'b0;
      cmd(hsd_pkg::QRY_DECOMP, hsd_pkg::ANS_NOT_READY);  // no frame
      frame_avail <= 1'b1;
      cmd(hsd_pkg::QRY_DECOMP, hsd_pkg::ANS_READY);      // frame waiting
      for (i = 0; i < 2; i++) begin
         comp_can_accept <= i[0];
         cmd(hsd_pkg::QRY_COMP, i[0] ? hsd_pkg::ANS_READY : hsd_pkg::ANS_NOT_READY);
      end
      slow <= 1'b1;
      rnd = lfsr(rnd);
      w   = {4'h1, rnd[11:0]};
      cmd(w, w);                                          // slow engine answer
      `CHK("pb word", w, pb_cmd_q)
      slow <= 1'b0;
      w = {hsd_pkg::C1_TAG, 3'h6, 7'h00};
      cmd(w, w | 16'h0001);                               // ready flag set
      pops = 0;
      for (i = 0; i < hsd_pkg::FRAME_WORDS; i++) begin
         if (i == 100) begin
            wr_bus(hsd_pkg::OFS_CMD, hsd_pkg::QRY_DECOMP);
            @(posedge clk);
            rd_bus(hsd_pkg::OFS_HWSTAT, 1'b1, 16'h0006);  // mid-frame word ignored
         end
         cmd(hsd_pkg::CMD_DUMMY, samp(i));                // next sample
      end
      repeat (2) @(posedge clk);
      `CHK("pops", hsd_pkg::FRAME_WORDS, pops)
      rd_bus(hsd_pkg::OFS_HWSTAT, 1'b1, 16'h0002);        // frame over
      frame_avail <= 1'b0;
      cmd(w, w);                                          // no frame yet
      cmd(16'hf400, 16'hf400);                            // compression start
      cmd(HALT_W, HALT_W);                                // halt while active
      `CHK("ended", 1'b0, decomp_active_q)
      // Short duplex loop closed by the idle word
      start_dec(3'h0, 2'h3);                              // decompression first
      cmd(16'hf400, 16'hf400);                            // compression after setup
      comp_can_accept <= 1'b0;
      cmd(hsd_pkg::QRY_DECOMP, hsd_pkg::ANS_NOT_READY);  // poll decompression
      cmd(hsd_pkg::QRY_COMP, hsd_pkg::ANS_NOT_READY);    // poll compression
      cmd(hsd_pkg::CMD_IDLE, hsd_pkg::ANS_READY);        // idle ends run
      `CHK("ended", 1'b0, decomp_active_q)
      repeat (3) @(posedge clk);
      finish_test();
   end
endmodule
`undef CHK
`default_nettype wire

// ---- verilog/hsd_core.sv ----
/*
 * Device-side command interpreter for host-to-host decompression.
 * Decodes host command words, answers from its own state, moves
 * decompressed samples out word by word, and forwards playback protocol
 * commands to the playback engine except during a frame transfer.
 * Assumes the sample source and playback engine share clk; the host
 * keeps the command-status handshake and never asserts rd and wr together.
 */
`default_nettype none

// Contract
// - Start word: 111111, format 9-7, zeros 6-3, method 2-1, bit0 zero; answer bit0 ready.
// - First start answer keeps ready clear; no samples exist yet.
// - Accepted command raises status-ready; reading the answer clears it.
// - Dummy word F000 presents next sample in status and raises status-ready.
// - Host reads status each time ready rises; the read clears status-ready.
// - Later start words request output; ready bit tells whether a frame exists.
// - While decompressing and no frame transfer runs, playback transfer commands pass on to the playback engine.
// - Halt or idle in the second setup slot ends decompression.
// - Query 5219 answers 0000 when a frame is ready, else 0001.
// - The decompression query means something only while decompression runs.
// - Format codes 000,010,100,101,110 valid; 001,011,111 reserved.
// - Query 5119 answers 0000 when compression accepts a frame, else 0001; the core ignores it during a frame transfer.
// - Idle command word 0000 returns the device to idle from the second setup slot or the active state.
module hsd_core #(
   parameter logic [15:0] HALT_CMD = 16'h5200  // Playback-halt word, decoded by the engine too
) (
   input  wire  logic        clk,
   input  wire  logic        resetn,
   input  wire  logic [1:0]  addr,
   input  wire  logic [15:0] wdata,
   input  wire  logic        wr,
   input  wire  logic        rd,
   output logic [15:0]       rdata_q,
   input  wire  logic        frame_avail,
   input  wire  logic [15:0] sample_data,
   output logic              sample_pop_q,
   input  wire  logic        comp_can_accept,
   output logic              pb_cmd_valid_q,
   output logic [15:0]       pb_cmd_q,
   input  wire  logic        pb_resp_valid,
   input  wire  logic [15:0] pb_resp_data,
   output logic              decomp_active_q,
   output logic [2:0]        playback_format_q,
   output logic [1:0]        transfer_method_q
);
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_SETUP2 = 3'b001,
      ST_SETUP3 = 3'b010,
      ST_ACTIVE = 3'b011,
      ST_XFER   = 3'b100
   } hsd_state_e;

   hsd_state_e  state_q, state_d;
   logic [7:0]  cnt_q;
   logic [15:0] resp_q, resp_d;
   logic        status_ready_q;
   logic        cmd_wr, is_c1, fmt_ok, resp_ld, fwd, pop;
   logic [2:0]  fmt;
   logic [15:0] hw_stat;

   // A halt word that aliases a local word would never reach the engine
   if (HALT_CMD == hsd_pkg::CMD_IDLE || HALT_CMD == hsd_pkg::CMD_DUMMY
       || HALT_CMD == hsd_pkg::QRY_DECOMP || HALT_CMD == hsd_pkg::QRY_COMP
       || HALT_CMD[hsd_pkg::TAG_HI:hsd_pkg::TAG_LO] == hsd_pkg::C1_TAG) begin : g_bad_halt
      $error("HALT_CMD collides with a fixed command word");
   end

   // Command decode
   assign cmd_wr = wr && (addr == hsd_pkg::OFS_CMD);
   assign fmt    = wdata[hsd_pkg::FMT_HI:hsd_pkg::FMT_LO];
   assign is_c1  = (wdata[hsd_pkg::TAG_HI:hsd_pkg::TAG_LO] == hsd_pkg::C1_TAG)
                   && (wdata[hsd_pkg::ZERO_HI:hsd_pkg::ZERO_LO] == 4'h0)
                   && !wdata[hsd_pkg::READY_BIT];
   assign fmt_ok = !(fmt == hsd_pkg::FMT_RSV_A || fmt == hsd_pkg::FMT_RSV_B
                     || fmt == hsd_pkg::FMT_RSV_C);

   // Next state, local answer and forwarding decision
   always_comb begin
      state_d = state_q;
      resp_ld = 1'b0;
      resp_d  = resp_q;
      fwd     = 1'b0;
      pop     = 1'b0;
      if (cmd_wr) begin
         if (wdata == hsd_pkg::QRY_COMP && state_q != ST_XFER) begin
            resp_ld = 1'b1;
            resp_d  = comp_can_accept ? hsd_pkg::ANS_READY : hsd_pkg::ANS_NOT_READY;
         end else begin
            case (state_q)
               ST_IDLE: begin
                  if (is_c1) begin
                     resp_ld = 1'b1;
                     resp_d  = {wdata[15:1], 1'b0};
                     if (fmt_ok) begin
                        state_d = ST_SETUP2;
                     end
                  end else if (wdata == hsd_pkg::QRY_DECOMP) begin
                     resp_ld = 1'b1;
                     resp_d  = hsd_pkg::ANS_NOT_READY;
                  end else begin
                     fwd = 1'b1;
                  end
               end
               ST_SETUP2: begin
                  // halt or idle in second slot
                  if (wdata == hsd_pkg::CMD_IDLE) begin
                     resp_ld = 1'b1;
                     resp_d  = hsd_pkg::CMD_IDLE;
                     state_d = ST_IDLE;
                  end else begin
                     fwd     = 1'b1;
                     state_d = (wdata == HALT_CMD) ? ST_IDLE : ST_SETUP3;
                  end
               end
               ST_SETUP3: begin
                  fwd     = 1'b1;
                  state_d = ST_ACTIVE;
               end
               ST_ACTIVE: begin
                  if (is_c1) begin
                     // later start word asks for output
                     resp_ld = 1'b1;
                     resp_d  = {wdata[15:1], frame_avail};
                     if (frame_avail) begin
                        state_d = ST_XFER;
                     end
                  end else if (wdata == hsd_pkg::QRY_DECOMP) begin
                     resp_ld = 1'b1;
                     resp_d  = frame_avail ? hsd_pkg::ANS_READY : hsd_pkg::ANS_NOT_READY;
                  end else if (wdata == hsd_pkg::CMD_IDLE) begin
                     resp_ld = 1'b1;
                     resp_d  = hsd_pkg::CMD_IDLE;
                     state_d = ST_IDLE;
                  end else begin
                     fwd = 1'b1;
                     if (wdata == HALT_CMD) begin
                        state_d = ST_IDLE;
                     end
                  end
               end
               ST_XFER: begin
                  if (wdata == hsd_pkg::CMD_DUMMY) begin
                     pop     = 1'b1;
                     resp_ld = 1'b1;
                     resp_d  = sample_data;
                     // frame ends after the last word
                     if (cnt_q == 8'(hsd_pkg::FRAME_WORDS - 1)) begin
                        state_d = ST_ACTIVE;
                     end
                  end
               end
               default: state_d = ST_IDLE;
            endcase
         end
      end
   end

   // State register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // word counter over the committed frame
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= 8'h00;
      end else if (state_q != ST_XFER) begin
         cnt_q <= 8'h00;
      end else if (pop) begin
         cnt_q <= cnt_q + 8'h01;
      end
   end

   // Response word; local answers outrank a late engine answer
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         resp_q <= 16'h0000;
      end else if (resp_ld) begin
         resp_q <= resp_d;
      end else if (pb_resp_valid) begin
         resp_q <= pb_resp_data;
      end
   end

   // status-ready, set wins over the clearing read
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         status_ready_q <= 1'b0;
      end else if (resp_ld || pb_resp_valid) begin
         status_ready_q <= 1'b1;
      end else if (rd && addr == hsd_pkg::OFS_STATUS) begin
         status_ready_q <= 1'b0;
      end
   end

   // Hardware status word, bit places kept in the package
   always_comb begin
      hw_stat                       = 16'h0000;
      hw_stat[hsd_pkg::HW_RDY_BIT]  = status_ready_q;
      hw_stat[hsd_pkg::HW_ACT_BIT]  = (state_q != ST_IDLE);
      hw_stat[hsd_pkg::HW_XFER_BIT] = (state_q == ST_XFER);
   end

   // Read data, one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= 16'h0000;
      end else if (rd) begin
         case (addr)
            hsd_pkg::OFS_STATUS: rdata_q <= resp_q;
            hsd_pkg::OFS_HWSTAT: rdata_q <= hw_stat;
            default:             rdata_q <= 16'h0000;
         endcase
      end else begin
         rdata_q <= 16'h0000;
      end
   end

   // Forwarding to the playback engine and sample pops
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pb_cmd_valid_q <= 1'b0;
         pb_cmd_q       <= 16'h0000;
         sample_pop_q   <= 1'b0;
      end else begin
         pb_cmd_valid_q <= fwd;
         sample_pop_q   <= pop;
         if (fwd) begin
            pb_cmd_q <= wdata;
         end
      end
   end

   // Mode outputs; format latched only on an accepted start
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         decomp_active_q   <= 1'b0;
         playback_format_q <= 3'h0;
         transfer_method_q <= 2'h0;
      end else begin
         decomp_active_q <= (state_d != ST_IDLE);
         if (state_q == ST_IDLE && state_d == ST_SETUP2) begin
            playback_format_q <= fmt;
            transfer_method_q <= wdata[hsd_pkg::TFR_HI:hsd_pkg::TFR_LO];
         end
      end
   end

   // Checks beside the logic
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   first_ready_a: assert property (cmd_wr && state_q == ST_IDLE && is_c1 |=> !resp_q[0])
      else $error("first start answer shows ready");
   echo_fields_a: assert property (cmd_wr && state_q == ST_IDLE && is_c1 |=> resp_q[15:1] == $past(wdata[15:1]))
      else $error("start answer does not echo fields");
   bad_fmt_a: assert property (cmd_wr && state_q == ST_IDLE && is_c1 && !fmt_ok |=> state_q == ST_IDLE)
      else $error("reserved format started decompression");
   stat_set_a: assert property (resp_ld |=> status_ready_q ##1 (status_ready_q || $past(rd)))
      else $error("status-ready not raised");
   stat_clr_a: assert property (rd && addr == hsd_pkg::OFS_STATUS && !resp_ld && !pb_resp_valid |=> !status_ready_q)
      else $error("status read did not clear ready");
   dummy_pop_a: assert property (cmd_wr && state_q == ST_XFER && wdata == hsd_pkg::CMD_DUMMY
                                 |=> sample_pop_q && resp_q == $past(sample_data))
      else $error("dummy word did not present sample");
   frame_end_a: assert property (pop && cnt_q == 8'(hsd_pkg::FRAME_WORDS - 1) |=> state_q == ST_ACTIVE)
      else $error("frame did not end after last word");
   out_req_a: assert property (cmd_wr && state_q == ST_ACTIVE && is_c1
                               |=> resp_q[0] == $past(frame_avail) && (state_q == ST_XFER) == resp_q[0])
      else $error("output request answer wrong");
   dec_query_a: assert property (cmd_wr && state_q == ST_ACTIVE && wdata == hsd_pkg::QRY_DECOMP
                                 |=> resp_q == {15'h0000, !$past(frame_avail)} && status_ready_q)
      else $error("decompression query answer wrong");
   comp_query_a: assert property (cmd_wr && state_q != ST_XFER && wdata == hsd_pkg::QRY_COMP
                                  |=> resp_q == {15'h0000, !$past(comp_can_accept)})
      else $error("compression query answer wrong");
   fwd_cmd_a: assert property (cmd_wr && state_q == ST_ACTIVE && !is_c1 && wdata != hsd_pkg::QRY_DECOMP
                               && wdata != hsd_pkg::QRY_COMP && wdata != hsd_pkg::CMD_IDLE
                               |=> pb_cmd_valid_q && pb_cmd_q == $past(wdata))
      else $error("playback command not forwarded");
   end_slot_a: assert property (cmd_wr && state_q == ST_SETUP2
                                && (wdata == hsd_pkg::CMD_IDLE || wdata == HALT_CMD)
                                |=> state_q == ST_IDLE && !decomp_active_q)
      else $error("second slot halt did not end decompression");
   idle_cmd_a: assert property (cmd_wr && state_q == ST_ACTIVE && wdata == hsd_pkg::CMD_IDLE
                                |=> state_q == ST_IDLE && !decomp_active_q)
      else $error("idle word did not return to idle");

   start_c: cover property (cmd_wr && state_q == ST_IDLE && is_c1 && fmt_ok);
   frame_c: cover property (pop && cnt_q == 8'(hsd_pkg::FRAME_WORDS - 1));
   query_c: cover property (cmd_wr && state_q == ST_ACTIVE && wdata == hsd_pkg::QRY_DECOMP && frame_avail);
   halt_c:  cover property (cmd_wr && state_q == ST_ACTIVE && wdata == HALT_CMD);
endmodule
`default_nettype wire
